// *** hw/smspi_buf.sv ***
// Two-entry valid/ready buffer between the shift engine and the receiver.
// Assumes both sides are on clk_sys.
`timescale 1ns/1ps
module smspi_buf #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } smspi_buf_s;
    smspi_buf_s state_r;
    smspi_buf_s state_nxt;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        state_nxt = state_r;
        if (push) begin
            state_nxt.mem[state_r.wp] = in_data;
            state_nxt.wp = (state_r.wp == PW'(DEPTH - 1)) ? '0 : state_r.wp + 1'b1;
        end
        if (pop) begin
            state_nxt.rp = (state_r.rp == PW'(DEPTH - 1)) ? '0 : state_r.rp + 1'b1;
        end
        state_nxt.cnt = state_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign in_ready = (state_r.cnt != (PW + 1)'(DEPTH));
    assign out_valid = (state_r.cnt != '0);
    assign out_data = state_r.mem[state_r.rp];
endmodule : smspi_buf

// *** hw/smspi_pkg.sv ***
// Package of shared constants for the serial master engine.
// Assumes a single system clock domain; the top and the bench refer to it by scope.
package smspi_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BYTE_BITS = 8;
    localparam logic [2:0] RATE_EXT = 3'h7;
    // Control register field positions.
    localparam int unsigned CTL_RATE2 = 7;
    localparam int unsigned CTL_ENABLE = 6;
    localparam int unsigned CTL_RSVD1 = 4;
    localparam int unsigned CTL_CLOCK_POLARITY_BIT = 3;
    localparam int unsigned CTL_CLOCK_PHASE_BIT = 2;
    localparam int unsigned CTL_RATE1 = 1;
    localparam int unsigned CTL_RATE0 = 0;
    localparam logic [7:0] CTL_RESET = 8'h14;
    // Status register field positions.
    localparam int unsigned STA_DONE = 7;
    localparam int unsigned STA_WRITE_COLLISION_FLAG = 6;
    localparam int unsigned STA_MODE_FAULT_FLAG = 4;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [6:0] DIV_RESET = 7'h00;
    localparam logic [3:0] EDGE_RESET = 4'h0;
endpackage : smspi_pkg

// *** hw/smspi_sync.sv ***
// Three-stage synchroniser for a pin input with a two-stage agreement filter.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
module smspi_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Pin in, filtered level out
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } smspi_sync_s;
    smspi_sync_s state_r;
    smspi_sync_s state_nxt;

    // The first stage only feeds the second, keeping metastability contained.
    always_comb begin
        state_nxt = state_r;
        state_nxt.stage = {state_r.stage[1:0], pin_in};
        if (state_r.stage[2] == state_r.stage[1]) begin
            state_nxt.level = state_r.stage[2];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= {{3{RESET_VAL}}, RESET_VAL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level_out = state_r.level;
endmodule : smspi_sync

// *** hw/smspi_top.sv ***
// Master-only serial port engine with control, status and data registers as plain ports.
// Assumes a core that issues one-cycle access strobes on clk_sys; select and
// data-in arrive from pins and are synchronised here.
// What this block does
// - Master only; one control register sets up.
// - Shift out and in on one clock.
// - Data write starts exchange when shifter idle.
// - Eighth bit sets done, latches receive byte.
// - Done clears on status read, data read.
// - Select low halts exchange when the select check is disabled; data kept.
// - Polarity only sets serial clock idle level.
// - Phase picks sampling and shifting edges.
// - Phase 0: first edge captures MSB.
// - Phase 1: master drives on first edge.
// - Select low as master sets fault.
// - Fault: request, clear enable and master.
// - Fault clears on status read, control write.
// - Busy data write flags collision only.
// - Collision clears on status, then data access.
// - Uncleared done keeps first byte; no overrun.
// - Done flag drives transmit interrupt request.
// - Fault drives error request unless check disabled.
// - Bytes travel MSB first on both lines.
// - Exactly eight serial clocks per byte.
// - Rate field divides by 2..128 or external.
`timescale 1ns/1ps
module smspi_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control register access
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] serial_ctrl_reg,
    // Status register access
    input wire logic status_rd,
    output logic [7:0] serial_status_reg,
    // Data register access
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] data_wdata,
    output logic [7:0] serial_data_reg,
    // Configuration
    input wire logic select_check_disable,
    // External baud generator tick
    input wire logic ext_rate_tick,
    // Serial pins
    output logic sck_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic ss_n_in,
    // Interrupt requests
    output logic tx_irq,
    output logic err_irq
);
    typedef enum logic [2:0] {
        SM_IDLE = 3'b001,
        SM_RUN = 3'b010,
        SM_HALT = 3'b100
    } smspi_state_e;

    typedef struct packed {
        smspi_state_e st;
        logic [7:0] ctrl;
        logic master_sel;
        logic done;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic done_armed;
        logic write_collision_flag_armed;
        logic mode_fault_flag_armed;
        logic [7:0] shreg;
        logic [7:0] rxbuf;
        logic [6:0] div;
        logic [3:0] edges;
        logic sck;
        logic mosi;
        logic ss_prev;
    } smspi_s;

    smspi_s state_r;
    smspi_s state_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic ss_n_s;
    logic miso_s;
    logic [6:0] div_max;
    logic half_tick;
    logic lead_edge;
    logic rx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic sent_valid;
    logic [2:0] rate;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    smspi_sync #(.RESET_VAL(1'b1)) u_ss_sync (
        .clk_sys(clk_sys),
        .reset_n(rst_n),
        .pin_in(ss_n_in),
        .level_out(ss_n_s)
    );

    smspi_sync #(.RESET_VAL(1'b0)) u_miso_sync (
        .clk_sys(clk_sys),
        .reset_n(rst_n),
        .pin_in(miso_in),
        .level_out(miso_s)
    );

    // Received bytes pass a small buffer that drains every cycle; its out_ready is tied high.
    smspi_buf #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(sent_valid),
        .in_ready(rx_ready),
        .in_data(state_nxt.shreg),
        .out_valid(rx_valid),
        .out_ready(1'b1),
        .out_data(rx_data)
    );

    assign rate = {state_r.ctrl[smspi_pkg::CTL_RATE2], state_r.ctrl[smspi_pkg::CTL_RATE1],
        state_r.ctrl[smspi_pkg::CTL_RATE0]};

    // Half a serial period is the divisor over two internal clocks.
    always_comb begin
        div_max = 7'h00;
        for (int i = 0; i < 7; i++) begin
            if (rate == 3'(i)) begin
                div_max = 7'((1 << i) - 1);
            end
        end
    end

    assign half_tick = (rate == smspi_pkg::RATE_EXT) ? ext_rate_tick
        : (state_r.div == div_max);
    // Odd half-periods leave idle; with phase 0 they sample, with phase 1 they shift.
    assign lead_edge = ~state_r.edges[0];

    always_comb begin
        state_nxt = state_r;
        sent_valid = 1'b0;
        state_nxt.ss_prev = ss_n_s;

        // A falling select while master is a fault; checking can be disabled.
        if (state_r.ss_prev && !ss_n_s && state_r.master_sel && !select_check_disable) begin
            state_nxt.mode_fault_flag = 1'b1;
            state_nxt.ctrl[smspi_pkg::CTL_ENABLE] = 1'b0;
            state_nxt.master_sel = 1'b0;
        end

        unique case (state_r.st)
            SM_IDLE: begin
                state_nxt.sck = state_r.ctrl[smspi_pkg::CTL_CLOCK_POLARITY_BIT];
                state_nxt.div = smspi_pkg::DIV_RESET;
                state_nxt.edges = smspi_pkg::EDGE_RESET;
                if (data_wr && state_r.ctrl[smspi_pkg::CTL_ENABLE] && state_r.master_sel) begin
                    state_nxt.shreg = data_wdata;
                    state_nxt.st = SM_RUN;
                    // Phase 0 presents the MSB before the first edge.
                    if (!state_r.ctrl[smspi_pkg::CTL_CLOCK_PHASE_BIT]) begin
                        state_nxt.mosi = data_wdata[7];
                    end
                end
            end
            SM_RUN: begin
                if (data_wr) begin
                    state_nxt.write_collision_flag = 1'b1;
                end
                if (!state_r.ctrl[smspi_pkg::CTL_ENABLE]) begin
                    state_nxt.st = SM_IDLE;
                end else if (!ss_n_s) begin
                    state_nxt.st = SM_HALT;
                end else if (half_tick) begin
                    state_nxt.div = smspi_pkg::DIV_RESET;
                    state_nxt.sck = ~state_r.sck;
                    state_nxt.edges = state_r.edges + 4'h1;
                    if (lead_edge == !state_r.ctrl[smspi_pkg::CTL_CLOCK_PHASE_BIT]) begin
                        state_nxt.shreg = {state_r.shreg[6:0], miso_s};
                    end else if (state_r.ctrl[smspi_pkg::CTL_CLOCK_PHASE_BIT] || state_r.edges != 4'h0) begin
                        state_nxt.mosi = state_r.ctrl[smspi_pkg::CTL_CLOCK_PHASE_BIT]
                            ? state_r.shreg[7] : state_r.shreg[7];
                    end
                    if (state_r.edges == 4'(2 * smspi_pkg::BYTE_BITS - 1)) begin
                        state_nxt.st = SM_IDLE;
                        sent_valid = 1'b1;
                    end
                end else begin
                    state_nxt.div = state_r.div + 7'h01;
                end
            end
            SM_HALT: begin
                state_nxt.sck = state_r.ctrl[smspi_pkg::CTL_CLOCK_POLARITY_BIT];
                if (!state_r.ctrl[smspi_pkg::CTL_ENABLE]) begin
                    state_nxt.st = SM_IDLE;
                end else if (ss_n_s) begin
                    state_nxt.st = SM_RUN;
                end
            end
            default: begin
                state_nxt.st = SM_IDLE;
            end
        endcase

        // The first byte after a clear stays; later ones are dropped silently.
        if (rx_valid && !state_r.done) begin
            state_nxt.done = 1'b1;
            state_nxt.rxbuf = rx_data;
        end

        // Clearing sequences: arm on status read, finish on the second access.
        if (status_rd) begin
            state_nxt.done_armed = state_r.done;
            state_nxt.write_collision_flag_armed = state_r.write_collision_flag;
            state_nxt.mode_fault_flag_armed = state_r.mode_fault_flag;
        end
        if (data_rd && state_r.done_armed && !(rx_valid && !state_r.done)) begin
            state_nxt.done = 1'b0;
            state_nxt.done_armed = 1'b0;
        end
        if ((data_rd || data_wr) && state_r.write_collision_flag_armed && !(state_r.st == SM_RUN && data_wr)) begin
            state_nxt.write_collision_flag = 1'b0;
            state_nxt.write_collision_flag_armed = 1'b0;
        end
        if (ctrl_wr) begin
            state_nxt.ctrl = ctrl_wdata;
            // The port stays off until the fault has been cleared.
            if (state_r.mode_fault_flag && !state_r.mode_fault_flag_armed) begin
                state_nxt.ctrl[smspi_pkg::CTL_ENABLE] = 1'b0;
            end
            if (state_r.mode_fault_flag_armed && state_nxt.mode_fault_flag == state_r.mode_fault_flag) begin
                state_nxt.mode_fault_flag = 1'b0;
                state_nxt.mode_fault_flag_armed = 1'b0;
                state_nxt.master_sel = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '{st: SM_IDLE, ctrl: smspi_pkg::CTL_RESET, master_sel: 1'b1,
                done: 1'b0, write_collision_flag: 1'b0, mode_fault_flag: 1'b0, done_armed: 1'b0, write_collision_flag_armed: 1'b0,
                mode_fault_flag_armed: 1'b0, shreg: smspi_pkg::DATA_RESET,
                rxbuf: smspi_pkg::DATA_RESET, div: smspi_pkg::DIV_RESET,
                edges: smspi_pkg::EDGE_RESET, sck: 1'b0, mosi: 1'b0, ss_prev: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign serial_ctrl_reg = state_r.ctrl;
    assign serial_status_reg = {state_r.done, state_r.write_collision_flag, 1'b0, state_r.mode_fault_flag, 4'h0};
    assign serial_data_reg = state_r.rxbuf;
    assign sck_out = state_r.sck;
    assign mosi_out = state_r.mosi;
    assign tx_irq = state_r.done;
    assign err_irq = state_r.mode_fault_flag && !select_check_disable;
endmodule : smspi_top

// *** verif/smspi_asserts.sv ***
// Checker for the serial master engine top.
// Assumes it is bound to smspi_top and sees only its ports.
`timescale 1ns/1ps
module smspi_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register side
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] serial_ctrl_reg,
    input wire logic status_rd,
    input wire logic [7:0] serial_status_reg,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] data_wdata,
    input wire logic [7:0] serial_data_reg,
    input wire logic select_check_disable,
    input wire logic ext_rate_tick,
    // Pins and requests
    input wire logic sck_out,
    input wire logic mosi_out,
    input wire logic miso_in,
    input wire logic ss_n_in,
    input wire logic tx_irq,
    input wire logic err_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_tx_irq; tx_irq == serial_status_reg[7]; endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq mismatch");
    property p_err_irq; err_irq |-> serial_status_reg[4] && !select_check_disable; endproperty
    a_err_irq: assert property (p_err_irq) else $error("err irq mismatch");
    property p_idle;
        (!serial_ctrl_reg[6] && $stable(serial_ctrl_reg)) [*3] |-> sck_out == serial_ctrl_reg[3];
    endproperty
    a_idle: assert property (p_idle) else $error("sck not idle");
    property p_fault_off; $rose(serial_status_reg[4]) |-> ##[0:1] !serial_ctrl_reg[6]; endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault left port on");
    property p_mode_fault_flag; $rose(serial_status_reg[4]) |-> !ss_n_in && !select_check_disable; endproperty
    a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("fault without select");
    property p_done_clr; $fell(serial_status_reg[7]) |-> $past(data_rd) || $past(data_rd, 2); endproperty
    a_done_clr: assert property (p_done_clr) else $error("done cleared early");
    property p_rx_load; $changed(serial_data_reg) |-> $rose(serial_status_reg[7]); endproperty
    a_rx_load: assert property (p_rx_load) else $error("rx byte moved");
    property p_halt; (select_check_disable && !ss_n_in) [*8] |=> $stable(sck_out); endproperty
    a_halt: assert property (p_halt) else $error("sck ran while halted");
endmodule : smspi_asserts

// *** verif/smspi_slave.sv ***
// Behavioural slave peripheral at the far side of the serial pins.
// Assumes the bench drives its select and it shares the master's format.
`timescale 1ns/1ps
module smspi_slave (
    // Serial pins
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    // Format and data
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    logic first;
    initial miso = 1'h0;
    always @(negedge ss_n) begin
        sh = tx_byte;
        first = 1'h1;
        miso = tx_byte[7];
    end
    // A released line shows the inverse of its last bit, so stale data cannot pass.
    always @(posedge ss_n) miso = ~miso;
    always @(sck) begin
        if (!ss_n && (sck ^ clock_polarity_bit ^ clock_phase_bit)) rx_byte = {rx_byte[6:0], mosi};
        else if (!ss_n) begin
            if (clock_phase_bit && first) first = 1'h0;
            else sh = {sh[6:0], 1'h0};
            miso = sh[7];
        end
    end
endmodule : smspi_slave

// *** verif/tb_top.sv ***
// Self-checking bench for the serial master engine with a slave model.
// Assumes the design, the slave model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'h0, reset_n = 1'h0, ctrl_wr = 1'h0, status_rd = 1'h0, data_wr = 1'h0;
    logic data_rd = 1'h0, select_check_disable = 1'h0, ext_rate_tick = 1'h0, ss_n_in = 1'h1;
    logic sl_ss_n = 1'h1;
    logic [7:0] ctrl_wdata = 8'h00, data_wdata = 8'h00, sl_tx = 8'h00;
    logic [7:0] serial_ctrl_reg, serial_status_reg, serial_data_reg, sl_rx;
    logic sck_out, mosi_out, miso_in, tx_irq, err_irq, sck_d;
    int errors = 0, checks = 0, tog = 0, cyc = 0, t1, t2;
    smspi_top i_smspi_top (.*);
    smspi_slave i_smspi_slave (.sck(sck_out), .ss_n(sl_ss_n), .mosi(mosi_out), .miso(miso_in),
        .clock_polarity_bit(serial_ctrl_reg[3]), .clock_phase_bit(serial_ctrl_reg[2]), .tx_byte(sl_tx), .rx_byte(sl_rx));
    initial forever #50 clk_sys = ~clk_sys;
    // Toggle stamps give the half period without depending on start latency.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        sck_d <= sck_out;
        ext_rate_tick <= (cyc % 5 == 4);
        if (sck_out !== sck_d) begin
            tog <= tog + 1;
            if (tog == 0) t1 <= cyc;
            if (tog == 1) t2 <= cyc;
        end
    end
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Kind 0 control write, 1 status read, 2 data write, 3 data read.
    task automatic acc(int k, logic [7:0] v);
        @(posedge clk_sys) #1;
        ctrl_wdata = v;
        data_wdata = v;
        ctrl_wr = (k == 0);
        status_rd = (k == 1);
        data_wr = (k == 2);
        data_rd = (k == 3);
        @(posedge clk_sys) #1;
        {ctrl_wr, status_rd, data_wr, data_rd} = 4'h0;
    endtask : acc
    task automatic clr();
        acc(1, 8'h00);
        acc(3, 8'h00);
        @(posedge clk_sys) #1;
        chk("done", 8'(serial_status_reg[7]), 8'h00);
        chk("write_collision_flag", 8'(serial_status_reg[6]), 8'h00);
    endtask : clr
    // Mode 1 writes again mid-byte; mode 2 pulls the select input low mid-byte.
    task automatic xfer(logic [7:0] tx, logic [7:0] sl, int mode);
        int n;
        sl_tx = sl;
        @(posedge clk_sys) #1;
        sl_ss_n = 1'h0;
        tog = 0;
        acc(2, tx);
        if (mode != 0) begin
            wait (tog == 4);
            if (mode == 1) acc(2, ~tx);
            else begin
                #1 ss_n_in = 1'h0;
                repeat (8) @(posedge clk_sys);
                n = tog;
                repeat (30) @(posedge clk_sys);
                chk("halt", 8'(tog - n), 8'h00);
                #1 ss_n_in = 1'h1;
            end
        end
        for (int i = 0; i < 3000 && tog < 16; i++) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
        #1;
        chk("toggles", 8'(tog), 8'h10);
        chk("done", 8'(serial_status_reg[7]), 8'h01);
        chk("tx_irq", 8'(tx_irq), 8'h01);
        chk("slave rx", sl_rx, tx);
        sl_ss_n = 1'h1;
    endtask : xfer
    task automatic t_reset();
        chk("ctrl", serial_ctrl_reg, smspi_pkg::CTL_RESET);
        chk("status", serial_status_reg, 8'h00);
        chk("data", serial_data_reg, smspi_pkg::DATA_RESET);
        chk("pins", {4'h0, sck_out, mosi_out, tx_irq, err_irq}, 8'h00);
        $display("reset test finished");
    endtask : t_reset
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            // The pin synchronisers need a half period well above their latency.
            acc(0, {4'h1, 2'(m), 2'h3});
            acc(0, {4'h5, 2'(m), 2'h3});
            repeat (3) @(posedge clk_sys);
            #1;
            chk("sck idle", 8'(sck_out), 8'(m / 2));
            xfer(8'hC1 + 8'(m), 8'h3A ^ 8'(m), 0);
            chk("rx byte", serial_data_reg, 8'h3A ^ 8'(m));
            clr();
        end
        $display("format test finished");
    endtask : t_modes
    task automatic t_rates();
        for (int r = 0; r < 8; r++) begin
            acc(0, {r[2], 3'h1, 2'h0, r[1:0]});
            acc(0, {r[2], 3'h5, 2'h0, r[1:0]});
            xfer(8'h96 ^ 8'(r), 8'h2D + 8'(r), 0);
            chk("half period", 8'(t2 - t1), r == 7 ? 8'h05 : 8'(1 << r));
            clr();
        end
        $display("rate test finished");
    endtask : t_rates
    task automatic t_coll();
        acc(0, 8'h53);
        xfer(8'h8E, 8'h4B, 1);
        chk("write_collision_flag", 8'(serial_status_reg[6]), 8'h01);
        chk("err_irq", 8'(err_irq), 8'h00);
        xfer(8'h17, 8'hE2, 0);
        chk("first kept", serial_data_reg, 8'h4B);
        clr();
        $display("collision test finished");
    endtask : t_coll
    task automatic t_fault();
        ss_n_in = 1'h0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("fault", 8'(serial_status_reg[4]), 8'h01);
        chk("err_irq", 8'(err_irq), 8'h01);
        chk("enable", 8'(serial_ctrl_reg[6]), 8'h00);
        tog = 0;
        acc(2, 8'h66);
        repeat (40) @(posedge clk_sys);
        #1;
        chk("no shift", 8'(tog), 8'h00);
        ss_n_in = 1'h1;
        acc(1, 8'h00);
        acc(0, 8'h11);
        chk("fault clear", 8'(serial_status_reg[4]), 8'h00);
        acc(0, 8'h53);
        chk("re-enable", serial_ctrl_reg, 8'h53);
        select_check_disable = 1'h1;
        ss_n_in = 1'h0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("masked", {6'h00, serial_status_reg[4], err_irq}, 8'h00);
        ss_n_in = 1'h1;
        repeat (8) @(posedge clk_sys);
        xfer(8'hD4, 8'h6B, 2);
        chk("rx kept", serial_data_reg, 8'h6B);
        clr();
        $display("fault test finished");
    endtask : t_fault
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset();
        t_modes();
        t_rates();
        t_coll();
        t_fault();
        wrap_up();
    end
    initial begin
        repeat (50000) @(posedge clk_sys);
        errors++;
        wrap_up();
    end
endmodule : tb_top
bind smspi_top smspi_asserts i_smspi_asserts (.*);
